// >>> src/gcr_pkg.sv
/*
 * Constants shared by the output pin control and calibration coefficient
 * register bank: register selects, field positions, reset values.
 * Assumes a serial register port that presents a 3-bit register select.
 */
package gcr_pkg;
    localparam logic [2:0] GCR_SEL_PIN_CTRL = 3'h5;
    localparam logic [2:0] GCR_SEL_OFFSET = 3'h6;
    localparam logic [2:0] GCR_SEL_FULL_SCALE = 3'h7;
    localparam int GCR_COEF_W = 24;
    localparam int GCR_CTRL_W = 8;
    localparam int GCR_BIT_UPPER_EN = 5;
    localparam int GCR_BIT_LOWER_EN = 4;
    localparam logic [7:0] GCR_CTRL_RESET = 8'h00;
    localparam logic [23:0] GCR_OFFSET_RESET = 24'h800000;
    localparam logic [7:0] GCR_CTRL_WMASK = 8'h3f;
    localparam int GCR_SPI_BITS = 8;
endpackage

// >>> src/gcr_pin_sync.sv
/*
 * Two-flip-flop synchroniser for a bundle of pin levels.
 * Assumes inputs are asynchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module gcr_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> src/gcr_regs.sv
/*
 * Output pin control and calibration coefficient register bank, reached
 * over a 4-wire serial port (mode 3: data shifted in on the rising edge
 * of sclk, out on the falling edge, msb first). Each frame is a command
 * byte (bit 6 = read, bits 5:3 = register select) then the data bytes.
 * Assumes sclk, cs_b, sdi and pin readback levels are asynchronous and
 * much slower than clk; they are sampled through two flip-flops.
 */
// What this block does
// - Upper pair enabled: pin 3 follows its data bit.
// - Upper pair enabled: pin 2 follows its data bit.
// - Lower pair enabled: pin 1 follows its data bit.
// - Lower pair enabled: pin 0 follows its data bit.
// - Reading control with upper pair enabled returns pin 3 and 2 levels.
// - Reading control with lower pair enabled returns pin 1 and 0 levels.
// - Offset coefficient is 24-bit read/write, resets to 0x800000.
// - Zero-scale calibration overwrites the offset coefficient.
// - Full-scale coefficient is 24-bit read/write, paired with offset.
// - Full-scale loads a per-unit factory value at power-on.
// - Full-scale calibration or a host write replaces full-scale value.
// - All registers are reached by the host only through the serial port.
// - Upper pair enable cleared returns pins 3 and 2 to analog use.
// - Lower pair enable cleared tristates pins 1 and 0.
`timescale 1ns/10ps
`default_nettype none
module gcr_regs
    import gcr_pkg::*;
#(
    parameter logic [23:0] FACTORY_FULL_SCALE = 24'h512340
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdi,
    output logic sdo,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic upper_pins_analog,
    input wire logic cal_zero_done,
    input wire logic cal_full_done,
    input wire logic [23:0] cal_result,
    output logic [23:0] offset_coef,
    output logic [23:0] full_scale_coef
);
    initial begin
        if (FACTORY_FULL_SCALE[23:20] != 4'h5
                || FACTORY_FULL_SCALE[3:0] != 4'h0) begin
            $error("factory full-scale must match 0x5XXXX0");
        end
    end

    typedef enum logic [1:0] {GCR_IDLE, GCR_CMD, GCR_DATA} gcr_state_e;

    function automatic logic [4:0] gcr_len(input logic [2:0] sel);
        if (sel == GCR_SEL_OFFSET || sel == GCR_SEL_FULL_SCALE) begin
            gcr_len = 5'(GCR_COEF_W);
        end else begin
            gcr_len = 5'(GCR_SPI_BITS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] in_meta_reg, in_sync_reg, in_last_reg;
    logic [3:0] pin_level;
    logic sclk_rise, sclk_fall, cs_act;

    // Reset to the idle levels of the pins, so that no false sclk edge
    // or frame select is seen in the first cycles after reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_meta_reg <= 3'h7;
            in_sync_reg <= 3'h7;
            in_last_reg <= 3'h7;
        end else if (ce) begin
            in_meta_reg <= {sclk, cs_b, sdi};
            in_sync_reg <= in_meta_reg;
            in_last_reg <= in_sync_reg;
        end
    end

    assign sclk_rise = ce && in_sync_reg[2] && !in_last_reg[2];
    assign sclk_fall = ce && !in_sync_reg[2] && in_last_reg[2];
    assign cs_act = !in_sync_reg[1];

    gcr_pin_sync #(.WIDTH(4)) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_reg;
    logic upper_en, lower_en;
    logic [7:0] ctrl_view;
    assign upper_en = ctrl_reg[GCR_BIT_UPPER_EN];
    assign lower_en = ctrl_reg[GCR_BIT_LOWER_EN];

    // Disabled pairs keep the stored bits in the view.
    always_comb begin
        ctrl_view = ctrl_reg;
        if (upper_en) ctrl_view[3:2] = pin_level[3:2];
        if (lower_en) ctrl_view[1:0] = pin_level[1:0];
    end

    gcr_state_e state_reg;
    logic [4:0] cnt_reg;
    logic [2:0] sel_reg;
    logic rd_reg;
    logic [23:0] sh_reg;
    logic [23:0] tx_reg;
    logic wr_pulse;
    logic [23:0] wr_data;
    logic [23:0] rd_value;

    always_comb begin
        if (sel_reg == GCR_SEL_OFFSET) rd_value = offset_coef;
        else if (sel_reg == GCR_SEL_FULL_SCALE) rd_value = full_scale_coef;
        else if (sel_reg == GCR_SEL_PIN_CTRL) rd_value = {ctrl_view, 16'h0000};
        else rd_value = 24'h000000;
    end

    assign wr_data = {sh_reg[22:0], in_sync_reg[0]};
    assign wr_pulse = sclk_rise && cs_act && state_reg == GCR_DATA
        && cnt_reg == 5'd1 && !rd_reg;

    // Serial frame engine; the only host route to any register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= GCR_IDLE;
            cnt_reg <= 5'h00;
            sel_reg <= 3'h0;
            rd_reg <= 1'b0;
            sh_reg <= 24'h000000;
            tx_reg <= 24'h000000;
            sdo <= 1'b1;
        end else if (ce) begin
            if (!cs_act) begin
                state_reg <= GCR_CMD;
                cnt_reg <= 5'(GCR_SPI_BITS);
                sdo <= 1'b1;
            end else if (sclk_rise) begin
                sh_reg <= wr_data;
                if (cnt_reg > 5'd1) begin
                    cnt_reg <= cnt_reg - 5'd1;
                end else if (state_reg == GCR_CMD) begin
                    state_reg <= GCR_DATA;
                    sel_reg <= wr_data[5:3];
                    rd_reg <= wr_data[6];
                    cnt_reg <= gcr_len(wr_data[5:3]);
                end else begin
                    state_reg <= GCR_CMD;
                    cnt_reg <= 5'(GCR_SPI_BITS);
                end
            end else if (sclk_fall && state_reg == GCR_DATA && rd_reg) begin
                if (cnt_reg == gcr_len(sel_reg)) begin
                    sdo <= rd_value[23];
                    tx_reg <= {rd_value[22:0], 1'b0};
                end else begin
                    sdo <= tx_reg[23];
                    tx_reg <= {tx_reg[22:0], 1'b0};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The top two bits are forced to zero; the host must write them zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= GCR_CTRL_RESET;
        end else if (ce && wr_pulse && sel_reg == GCR_SEL_PIN_CTRL) begin
            ctrl_reg <= wr_data[7:0] & GCR_CTRL_WMASK;
        end
    end

    // Converter mode is not checked: writes during conversion are the
    // host's fault and simply land.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            offset_coef <= GCR_OFFSET_RESET;
        end else if (ce) begin
            if (cal_zero_done) offset_coef <= cal_result;
            else if (wr_pulse && sel_reg == GCR_SEL_OFFSET)
                offset_coef <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            full_scale_coef <= FACTORY_FULL_SCALE;
        end else if (ce) begin
            if (cal_full_done) full_scale_coef <= cal_result;
            else if (wr_pulse && sel_reg == GCR_SEL_FULL_SCALE)
                full_scale_coef <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
            upper_pins_analog <= 1'b1;
        end else if (ce) begin
            pin_out[3] <= ctrl_reg[3];
            pin_out[2] <= ctrl_reg[2];
            pin_out[1] <= ctrl_reg[1];
            pin_out[0] <= ctrl_reg[0];
            pin_oe[3:2] <= {2{upper_en}};
            pin_oe[1:0] <= {2{lower_en}};
            upper_pins_analog <= !upper_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_upper_drive: assert property (@(posedge clk) disable iff (!rst_b)
        ce && upper_en |=> pin_oe[3] && pin_out[3] == $past(ctrl_reg[3])
        && pin_out[2] == $past(ctrl_reg[2]))
        else $error("upper pins not driven from data bits");
    a_pin2_drive: assert property (@(posedge clk) disable iff (!rst_b)
        ce && upper_en |=> pin_oe[2])
        else $error("pin 2 not enabled");
    a_lower_drive: assert property (@(posedge clk) disable iff (!rst_b)
        ce && lower_en |=> pin_oe[1:0] == 2'b11
        && pin_out[1:0] == $past(ctrl_reg[1:0]))
        else $error("lower pins not driven");
    a_lower_tristate: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && !lower_en |=> pin_oe[1:0] == 2'b00)
        else $error("lower pins driven while disabled");
    a_upper_analog: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && !upper_en |=> upper_pins_analog && pin_oe[3:2] == 2'b00)
        else $error("upper pins not analog");
    // Readback is held against the pin two cycles back, which is what
    // the synchroniser must deliver when it has run for both cycles.
    a_read_pins: assert property (@(posedge clk) disable iff (!rst_b)
        upper_en && $past(ce) && $past(ce, 2) && $past(rst_b, 2)
        |-> ctrl_view[3:2] == $past(pin_in[3:2], 2))
        else $error("upper readback not pin level");
    a_read_low: assert property (@(posedge clk) disable iff (!rst_b)
        lower_en && $past(ce) && $past(ce, 2) && $past(rst_b, 2)
        |-> ctrl_view[1:0] == $past(pin_in[1:0], 2))
        else $error("lower readback not pin level");
    a_read_stored: assert property (@(posedge clk)
        disable iff (!rst_b)
        !lower_en |-> ctrl_view[1:0] == ctrl_reg[1:0])
        else $error("disabled readback not stored");
    a_zero_cal: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cal_zero_done |=> offset_coef == $past(cal_result))
        else $error("offset not loaded by calibration");
    a_full_cal: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cal_full_done |=> full_scale_coef == $past(cal_result))
        else $error("full scale not loaded by calibration");
    a_top_zero: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_reg[7:6] == 2'b00)
        else $error("top control bits set");

    c_ctrl_write: cover property (@(posedge clk) disable iff (!rst_b)
        wr_pulse && sel_reg == GCR_SEL_PIN_CTRL);
    c_off_write: cover property (@(posedge clk) disable iff (!rst_b)
        wr_pulse && sel_reg == GCR_SEL_OFFSET);
    c_fs_read: cover property (@(posedge clk) disable iff (!rst_b)
        state_reg == GCR_DATA && rd_reg && sel_reg == GCR_SEL_FULL_SCALE);
    c_cal: cover property (@(posedge clk) disable iff (!rst_b)
        cal_zero_done ##[1:20] cal_full_done);
endmodule
`default_nettype wire

// >>> testbench/gcr_spi_host.sv
/* Serial host model for the register port, mode 3, msb first.
   Assumes clk is the design clock; sclk half period is HALF clk cycles. */
`timescale 1ns/10ps
`default_nettype none
module gcr_spi_host #(
    parameter int HALF = 6
) (
    input wire logic clk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_b,
    output logic sdi
);
    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
        sdi = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // The bench never starts a conversion, so coefficient writes always
    // find the converter idle.
    task automatic xfer(input logic rd_en, input logic [2:0] sel,
        input int n, input logic [23:0] wd, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {1'b0, rd_en, sel, 3'h0, wd << (24 - n)};
        if (sel == 3'h5) begin
            sh[23:22] = 2'b00;
        end
        rd = '0;
        @(posedge clk);
        cs_b <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < 8 + n; i++) begin
            sclk <= 1'b0;
            sdi <= sh[31 - i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            if (i >= 8) begin
                rd = {rd[22:0], sdo};
            end
            repeat (HALF) @(posedge clk);
        end
        cs_b <= 1'b1;
        // A released data line must not keep showing the last bit.
        sdi <= ~sdi;
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
/* Self-checking bench for the pin control and coefficient registers.
   Assumes the serial host model drives every register access. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import gcr_pkg::*;
;
    localparam logic [23:0] FS = 24'h5abcd0;
    logic clk = 1'b0;
    logic rst_b, ce, sclk, cs_b, sdi, sdo, upper_pins_analog;
    logic cal_zero_done, cal_full_done;
    logic [3:0] pin_in, pin_out, pin_oe, ext_lvl, pull;
    logic [23:0] cal_result, offset_coef, full_scale_coef, rv;
    int num_errors = 0;
    int tests_run = 0;
    always #4 clk = ~clk;
    // A pulled pin shows the external level even while it is driven.
    assign pin_in = (pin_oe & ~pull & pin_out) | (~(pin_oe & ~pull) & ext_lvl);
    gcr_regs #(.FACTORY_FULL_SCALE(FS)) u_gcr_regs (.clk(clk),
        .rst_b(rst_b), .ce(ce), .sclk(sclk), .cs_b(cs_b), .sdi(sdi),
        .sdo(sdo), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .upper_pins_analog(upper_pins_analog),
        .cal_zero_done(cal_zero_done), .cal_full_done(cal_full_done),
        .cal_result(cal_result), .offset_coef(offset_coef),
        .full_scale_coef(full_scale_coef));
    gcr_spi_host u_gcr_spi_host (.clk(clk), .sdo(sdo), .sclk(sclk),
        .cs_b(cs_b), .sdi(sdi));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [23:0] seen,
        input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic r, input logic [2:0] s, input int n,
        input logic [23:0] d);
        u_gcr_spi_host.xfer(r, s, n, d, rv);
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] pat;
        logic [31:0] ctl, exp_rd;
        logic [15:0] exp_oe;
        logic [2:0] s;
        logic [23:0] cv;
        rst_b = 1'b0;
        ce = 1'b1;
        cal_zero_done = 1'b0;
        cal_full_done = 1'b0;
        cal_result = '0;
        ext_lvl = 4'h0;
        pull = 4'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("oe reset", pin_oe, 24'h0);
        check("analog reset", upper_pins_analog, 24'h1);
        acc(1'b1, GCR_SEL_OFFSET, 24, 24'h0);
        check("offset reset", rv, GCR_OFFSET_RESET);
        acc(1'b1, GCR_SEL_FULL_SCALE, 24, 24'h0);
        check("fs reset", rv, FS);
        check("fs nibbles", {rv[23:20], rv[3:0]}, 24'h50);
        acc(1'b1, 3'h3, 8, 24'h0);
        check("unmapped", rv, 24'h0);
        pat = 16'h5af0;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, GCR_SEL_PIN_CTRL, 8, {20'h3, pat[15 - 4 * i -: 4]});
            check("pin_out", pin_out,
                pat[15 - 4 * i -: 4]);
            check("pin_oe", pin_oe, 24'hf);
            check("analog", upper_pins_analog, 24'h0);
        end
        // Every pin is pulled to 0110 against its own drive of 1.
        ext_lvl <= 4'h6;
        pull <= 4'hf;
        ctl = 32'h3f2f1f0f;
        exp_rd = 32'h36271e0f;
        exp_oe = 16'hfc30;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, GCR_SEL_PIN_CTRL, 8, {16'h0, ctl[31 - 8 * i -: 8]});
            check("oe", pin_oe, exp_oe[15 - 4 * i -: 4]);
            check("analog", upper_pins_analog, !ctl[29 - 8 * i]);
            acc(1'b1, GCR_SEL_PIN_CTRL, 8, 24'h0);
            check("ctrl rd", rv,
                exp_rd[31 - 8 * i -: 8]);
        end
        pull <= 4'h0;
        for (int i = 0; i < 2; i++) begin
            s = (i != 0) ? GCR_SEL_FULL_SCALE : GCR_SEL_OFFSET;
            cv = (i != 0) ? 24'h654321 : 24'h123456;
            acc(1'b0, s, 24, cv);
            check("coef port", (i != 0) ? full_scale_coef : offset_coef,
                cv);
            acc(1'b1, s, 24, 24'h0);
            check("coef rd", rv, cv);
        end
        cal_result <= 24'h0a0b0c;
        cal_zero_done <= 1'b1;
        @(posedge clk);
        cal_zero_done <= 1'b0;
        cal_full_done <= 1'b1;
        cal_result <= 24'h0d0e0f;
        @(posedge clk);
        cal_full_done <= 1'b0;
        repeat (2) @(posedge clk);
        check("offset cal", offset_coef, 24'h0a0b0c);
        check("fs cal", full_scale_coef, 24'h0d0e0f);
        acc(1'b1, GCR_SEL_FULL_SCALE, 24, 24'h0);
        check("fs cal rd", rv, 24'h0d0e0f);
        // With the enable low a calibration pulse must not land.
        ce <= 1'b0;
        cal_result <= 24'h111111;
        cal_zero_done <= 1'b1;
        @(posedge clk);
        cal_zero_done <= 1'b0;
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        check("offset frozen", offset_coef, 24'h0a0b0c);
        // A reset in mid-run must bring back every reset value.
        acc(1'b0, GCR_SEL_PIN_CTRL, 8, 24'h00003f);
        check("oe before rst", pin_oe, 24'hf);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("oe rst", pin_oe, 24'h0);
        check("analog rst", upper_pins_analog, 24'h1);
        check("offset rst", offset_coef, GCR_OFFSET_RESET);
        check("fs rst", full_scale_coef, FS);
        acc(1'b1, GCR_SEL_PIN_CTRL, 8, 24'h0);
        check("ctrl rst rd", rv, 24'h0);
        stop_test;
    end
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
